// ---- logic/afm_map.vh ----
`ifndef AFM_MAP_VH
`define AFM_MAP_VH

// Register offsets (byte addresses)
`define AFM_OFS_SER_CTL 8'h04
`define AFM_OFS_TX_DATA 8'h08
`define AFM_OFS_RX_DATA 8'h0c
`define AFM_OFS_DIG_CTL 8'h10
`define AFM_OFS_SPDIF_DATA 8'h14
`define AFM_OFS_HDMI_DATA 8'h20
`define AFM_OFS_SHARED_DATA 8'h30

// Serial FIFO control fields
`define AFM_TX_MIX_SEL_HI 20
`define AFM_TX_MIX_SEL_LO 19
`define AFM_TX_SRC_BIT 18
`define AFM_RX_EMPTY_BIT 17
`define AFM_TX_KARA_BIT 15
`define AFM_RX_IRQ_PEND_BIT 12
`define AFM_RX_IRQ_EN_BIT 11
`define AFM_RX_DMA_EN_BIT 10
`define AFM_RX_RUN_BIT 9
`define AFM_TX_FULL_BIT 8
`define AFM_TX_IRQ_PEND_BIT 3
`define AFM_TX_IRQ_EN_BIT 2
`define AFM_TX_DMA_EN_BIT 1
`define AFM_TX_RUN_BIT 0

// Digital output FIFO control fields
`define AFM_HDMI_MIX_SEL_HI 16
`define AFM_HDMI_MIX_SEL_LO 15
`define AFM_HDMI_SRC_BIT 14
`define AFM_SPDIF_SRC_BIT 13
`define AFM_HDMI_KARA_BIT 12
`define AFM_SPDIF_KARA_BIT 11
`define AFM_SPDIF_EN_BIT 10
`define AFM_HDMI_IRQ_EN_BIT 9
`define AFM_HDMI_DMA_EN_BIT 8
`define AFM_HDMI_FULL_BIT 7
`define AFM_HDMI_IRQ_PEND_BIT 6
`define AFM_SPDIF_IRQ_EN_BIT 5
`define AFM_SPDIF_DMA_EN_BIT 4
`define AFM_SPDIF_FULL_BIT 3
`define AFM_SPDIF_IRQ_PEND_BIT 2
`define AFM_HDMI_RUN_BIT 1
`define AFM_SPDIF_RUN_BIT 0

// Sample field within data words
`define AFM_SAMPLE_HI 31
`define AFM_SAMPLE_LO 8

// Reset values as read back
`define AFM_SER_CTL_RESET 32'h0002_0000
`define AFM_DIG_CTL_RESET 32'h0000_0000

// FIFO depths and DMA threshold
`define AFM_TX_DEPTH 32
`define AFM_RX_DEPTH 16
`define AFM_SPDIF_DEPTH 32
`define AFM_HDMI_DEPTH 32
`define AFM_DMA_LEVEL 16

// Mix target selects
`define AFM_MIX_ALL 2'h0
`define AFM_MIX_FRONT 2'h1
`define AFM_MIX_FRONT_C 2'h2
`define AFM_MIX_CENTRE 2'h3

// Channel layouts of an output stream
`define AFM_CHM_STEREO 2'h0
`define AFM_CHM_51 2'h1
`define AFM_CHM_71 2'h2

// Channel slots in stream order
`define AFM_CH_FL 3'h0
`define AFM_CH_FR 3'h1
`define AFM_CH_C 3'h3

`endif

// ---- logic/afm_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module afm_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk,
  input wire clr,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head_data,
  output wire full,
  output wire empty,
  output wire [AW:0] level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;

  // Full drops pushes, empty drops pops: stored words never disturbed
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign full = (count == DEPTH[AW:0]);
  assign empty = (count == {(AW+1){1'b0}});
  assign level = count;
  assign head_data = mem[rptr];

  // Storage, no reset needed on the words themselves
  always @(posedge mclk) begin
    if (do_push && !clr) begin
      mem[wptr] <= push_data;
    end
  end

  // Pointers wrap at DEPTH so non power-of-two depths also work
  always @(posedge mclk) begin
    if (clr) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end

endmodule // afm_fifo

`default_nettype wire

// ---- logic/afm_mix_ctl.v ----
// What this block does
// [R01] Bits 20:19 pick which transmit channels get the received voice mixed in.
// [R02] Bit 18 feeds the transmit FIFO from its own register or the shared port.
// [R03] Bit 17 reads one while the receive FIFO is empty; resets to one.
// [R04] Bit 15 turns on voice mixing into the serial transmit stream.
// [R05] Receive-full sets pending bit 12, cleared by writing one; bit 11 enables.
// [R06] Bit 10 lets a full receive FIFO raise its DMA request.
// [R07] Bit 8 reads one while the transmit FIFO is full; resets to zero.
// [R08] Transmit-empty sets pending bit 3, cleared by writing one; bit 2 enables.
// [R09] Bit 1 lets an empty transmit FIFO raise its DMA request.
// [R10] Bit 0 and bit 9 hold transmit and receive FIFOs in reset while zero.
// [R11] Transmit data register takes one 24-bit sample in bits 31:8 per write.
// [R12] Reading receive data returns the oldest sample in bits 31:8 and pops it.
// [R13] Bits 16:15 pick which HDMI channels get the received voice mixed in.
// [R14] Bits 14 and 13 pick HDMI and S/PDIF FIFO write sources.
// [R15] Bits 12 and 11 enable voice mixing into HDMI and S/PDIF data.
// [R16] Bit 10 enables S/PDIF output; clearing it resets the S/PDIF path state.
// [R17] HDMI-empty sets pending bit 6, cleared by writing one; bit 9 enables.
// [R18] Bit 8 raises HDMI DMA request once 16 or fewer levels remain.
// [R19] Bits 7 and 3 read HDMI and S/PDIF FIFO full; both reset to zero.
// [R20] S/PDIF-empty sets pending bit 2, cleared by writing one; bit 5 enables.
// [R21] Bit 4 raises S/PDIF DMA request at 16 or fewer levels.
// [R22] Bits 1 and 0 hold HDMI and S/PDIF FIFOs in reset while zero.
// [R23] Shared port writes copy into every FIFO whose source select picks it.
// [R24] Software writes multichannel samples FL, FR, SW, C, BL, BR, SBL, SBR.
// [R25] Interrupt output is high while any pending bit meets its enable.
// [R26] Writes to full or held FIFOs, reads of empty FIFO, change nothing.
`timescale 1ns/1ps
`default_nettype none
`include "afm_map.vh"

module afm_mix_ctl #(
  parameter TX_DEPTH = `AFM_TX_DEPTH,
  parameter RX_DEPTH = `AFM_RX_DEPTH,
  parameter SPDIF_DEPTH = `AFM_SPDIF_DEPTH,
  parameter HDMI_DEPTH = `AFM_HDMI_DEPTH
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  input wire tx_pop,
  input wire [1:0] tx_chan_mode,
  output reg [23:0] tx_sample,
  output wire tx_empty,
  input wire rx_push,
  input wire [23:0] rx_sample_in,
  output wire rx_full,
  input wire spdif_pop,
  output reg [23:0] spdif_sample,
  output wire spdif_empty,
  output wire spdif_tx_en_out,
  input wire hdmi_pop,
  input wire [1:0] hdmi_chan_mode,
  output reg [23:0] hdmi_sample,
  output wire hdmi_empty,
  output wire irq,
  output wire tx_dma_req,
  output wire rx_dma_req,
  output wire spdif_dma_req,
  output wire hdmi_dma_req
);

  localparam TX_AW = 5;
  localparam RX_AW = 4;
  localparam SPDIF_AW = 5;
  localparam HDMI_AW = 5;

  // Serial FIFO control fields
  reg [1:0] tx_mix_target_sel;
  reg tx_fifo_src_sel;
  reg tx_karaoke_mix_en;
  reg rx_full_irq_pending;
  reg rx_full_irq_en;
  reg rx_full_dma_req_en;
  reg rx_fifo_run;
  reg tx_empty_irq_pending;
  reg tx_empty_irq_en;
  reg tx_empty_dma_req_en;
  reg tx_fifo_run;

  // Digital output control fields
  reg [1:0] hdmi_mix_target_sel;
  reg hdmi_fifo_src_sel;
  reg spdif_fifo_src_sel;
  reg hdmi_karaoke_mix_en;
  reg spdif_karaoke_mix_en;
  reg spdif_tx_en;
  reg hdmi_empty_irq_en;
  reg hdmi_dma_req_en;
  reg hdmi_empty_irq_pending;
  reg spdif_empty_irq_en;
  reg spdif_dma_req_en;
  reg spdif_empty_irq_pending;
  reg hdmi_fifo_run;
  reg spdif_fifo_run;

  // Path state
  reg [23:0] voice;
  reg [2:0] tx_chan;
  reg [2:0] hdmi_chan;
  reg [2:0] spdif_chan;
  reg tx_empty_d;
  reg rx_full_d;
  reg hdmi_empty_d;
  reg spdif_empty_d;

  wire [23:0] wr_sample;
  wire wr_ser_ctl;
  wire wr_dig_ctl;
  wire wr_tx_direct;
  wire wr_spdif_direct;
  wire wr_hdmi_direct;
  wire wr_shared;
  wire tx_push;
  wire spdif_push;
  wire hdmi_push;
  wire rx_pop;
  wire tx_full;
  wire spdif_full;
  wire hdmi_full;
  wire rx_empty;
  wire [23:0] tx_head;
  wire [23:0] rx_head;
  wire [23:0] spdif_head;
  wire [23:0] hdmi_head;
  wire [TX_AW:0] tx_level;
  wire [RX_AW:0] rx_level;
  wire [SPDIF_AW:0] spdif_level;
  wire [HDMI_AW:0] hdmi_level;
  wire tx_take;
  wire spdif_take;
  wire hdmi_take;
  wire [31:0] ser_ctl_view;
  wire [31:0] dig_ctl_view;

  // Signed 24-bit add clipped at full scale, so loud voice cannot wrap
  function [23:0] sat_add;
    input [23:0] a;
    input [23:0] b;
    reg [24:0] s;
    begin
      s = {a[23], a} + {b[23], b};
      if (s[24] != s[23]) begin
        sat_add = s[24] ? 24'h80_0000 : 24'h7f_ffff;
      end else begin
        sat_add = s[23:0];
      end
    end
  endfunction

  // Is this channel slot a mix target; stereo streams mix everywhere
  function mix_hit;
    input [1:0] sel;
    input [1:0] chm;
    input [2:0] chan;
    input centre_in_front;
    begin
      if (chm == `AFM_CHM_STEREO) begin
        mix_hit = 1'b1;
      end else begin
        case (sel)
          `AFM_MIX_ALL: mix_hit = 1'b1;
          `AFM_MIX_FRONT: mix_hit = (chan == `AFM_CH_FL) || (chan == `AFM_CH_FR);
          `AFM_MIX_FRONT_C: mix_hit = (chan == `AFM_CH_FL) || (chan == `AFM_CH_FR) ||
            (centre_in_front && (chan == `AFM_CH_C));
          `AFM_MIX_CENTRE: mix_hit = (chan == `AFM_CH_C);
          default: mix_hit = 1'b0;
        endcase
      end
    end
  endfunction

  // Next channel slot, wrapping at the stream's channel count
  function [2:0] next_chan;
    input [1:0] chm;
    input [2:0] chan;
    reg [2:0] last;
    begin
      case (chm)
        `AFM_CHM_51: last = 3'h5;
        `AFM_CHM_71: last = 3'h7;
        default: last = 3'h1;
      endcase
      next_chan = (chan == last) ? 3'h0 : chan + 3'h1;
    end
  endfunction

  // Address decode of bus writes
  assign wr_sample = reg_wdata[`AFM_SAMPLE_HI:`AFM_SAMPLE_LO];
  assign wr_ser_ctl = reg_wr && (reg_addr == `AFM_OFS_SER_CTL);
  assign wr_dig_ctl = reg_wr && (reg_addr == `AFM_OFS_DIG_CTL);
  assign wr_tx_direct = reg_wr && (reg_addr == `AFM_OFS_TX_DATA);
  assign wr_spdif_direct = reg_wr && (reg_addr == `AFM_OFS_SPDIF_DATA);
  assign wr_hdmi_direct = reg_wr && (reg_addr == `AFM_OFS_HDMI_DATA);
  assign wr_shared = reg_wr && (reg_addr == `AFM_OFS_SHARED_DATA);

  // [R02] [R11] transmit source select
  assign tx_push = tx_fifo_src_sel ? wr_shared : wr_tx_direct;
  // [R14] [R23] digital sources and fan-out
  assign spdif_push = spdif_fifo_src_sel ? wr_shared : wr_spdif_direct;
  assign hdmi_push = hdmi_fifo_src_sel ? wr_shared : wr_hdmi_direct;

  // [R12] pop on data read
  assign rx_pop = reg_rd && (reg_addr == `AFM_OFS_RX_DATA) && !rx_empty;

  // [R16] S/PDIF drains only while its transmitter is enabled
  assign tx_take = tx_pop && !tx_empty;
  assign spdif_take = spdif_pop && !spdif_empty && spdif_tx_en;
  assign hdmi_take = hdmi_pop && !hdmi_empty;
  assign spdif_tx_en_out = spdif_tx_en;

  // [R10] [R26] transmit FIFO held while not running
  afm_fifo #(
    .WIDTH(24),
    .DEPTH(TX_DEPTH),
    .AW(TX_AW)
  ) u_tx_fifo (
    .mclk(mclk),
    .clr(rst | ~tx_fifo_run),
    .push(tx_push),
    .push_data(wr_sample),
    .pop(tx_take),
    .head_data(tx_head),
    .full(tx_full),
    .empty(tx_empty),
    .level(tx_level)
  );

  // [R10] [R26] receive FIFO held while not running
  afm_fifo #(
    .WIDTH(24),
    .DEPTH(RX_DEPTH),
    .AW(RX_AW)
  ) u_rx_fifo (
    .mclk(mclk),
    .clr(rst | ~rx_fifo_run),
    .push(rx_push),
    .push_data(rx_sample_in),
    .pop(rx_pop),
    .head_data(rx_head),
    .full(rx_full),
    .empty(rx_empty),
    .level(rx_level)
  );

  // [R22] [R26] S/PDIF FIFO held while not running
  afm_fifo #(
    .WIDTH(24),
    .DEPTH(SPDIF_DEPTH),
    .AW(SPDIF_AW)
  ) u_spdif_fifo (
    .mclk(mclk),
    .clr(rst | ~spdif_fifo_run),
    .push(spdif_push),
    .push_data(wr_sample),
    .pop(spdif_take),
    .head_data(spdif_head),
    .full(spdif_full),
    .empty(spdif_empty),
    .level(spdif_level)
  );

  // [R22] [R26] HDMI FIFO held while not running
  afm_fifo #(
    .WIDTH(24),
    .DEPTH(HDMI_DEPTH),
    .AW(HDMI_AW)
  ) u_hdmi_fifo (
    .mclk(mclk),
    .clr(rst | ~hdmi_fifo_run),
    .push(hdmi_push),
    .push_data(wr_sample),
    .pop(hdmi_take),
    .head_data(hdmi_head),
    .full(hdmi_full),
    .empty(hdmi_empty),
    .level(hdmi_level)
  );

  // Serial control register and its sticky flags
  always @(posedge mclk) begin
    if (rst) begin
      tx_mix_target_sel <= `AFM_MIX_ALL;
      tx_fifo_src_sel <= 1'b0;
      tx_karaoke_mix_en <= 1'b0;
      rx_full_irq_pending <= 1'b0;
      rx_full_irq_en <= 1'b0;
      rx_full_dma_req_en <= 1'b0;
      rx_fifo_run <= 1'b0;
      tx_empty_irq_pending <= 1'b0;
      tx_empty_irq_en <= 1'b0;
      tx_empty_dma_req_en <= 1'b0;
      tx_fifo_run <= 1'b0;
    end else begin
      if (wr_ser_ctl) begin
        tx_mix_target_sel <= reg_wdata[`AFM_TX_MIX_SEL_HI:`AFM_TX_MIX_SEL_LO];
        tx_fifo_src_sel <= reg_wdata[`AFM_TX_SRC_BIT];
        tx_karaoke_mix_en <= reg_wdata[`AFM_TX_KARA_BIT];
        rx_full_irq_en <= reg_wdata[`AFM_RX_IRQ_EN_BIT];
        rx_full_dma_req_en <= reg_wdata[`AFM_RX_DMA_EN_BIT];
        rx_fifo_run <= reg_wdata[`AFM_RX_RUN_BIT];
        tx_empty_irq_en <= reg_wdata[`AFM_TX_IRQ_EN_BIT];
        tx_empty_dma_req_en <= reg_wdata[`AFM_TX_DMA_EN_BIT];
        tx_fifo_run <= reg_wdata[`AFM_TX_RUN_BIT];
      end
      // [R05] set on full edge, set beats clear
      if (rx_full && !rx_full_d) begin
        rx_full_irq_pending <= 1'b1;
      end else if (wr_ser_ctl && reg_wdata[`AFM_RX_IRQ_PEND_BIT]) begin
        rx_full_irq_pending <= 1'b0;
      end
      // [R08] set on empty edge, set beats clear
      if (tx_empty && !tx_empty_d) begin
        tx_empty_irq_pending <= 1'b1;
      end else if (wr_ser_ctl && reg_wdata[`AFM_TX_IRQ_PEND_BIT]) begin
        tx_empty_irq_pending <= 1'b0;
      end
    end
  end

  // Digital output control register and its sticky flags
  always @(posedge mclk) begin
    if (rst) begin
      hdmi_mix_target_sel <= `AFM_MIX_ALL;
      hdmi_fifo_src_sel <= 1'b0;
      spdif_fifo_src_sel <= 1'b0;
      hdmi_karaoke_mix_en <= 1'b0;
      spdif_karaoke_mix_en <= 1'b0;
      spdif_tx_en <= 1'b0;
      hdmi_empty_irq_en <= 1'b0;
      hdmi_dma_req_en <= 1'b0;
      hdmi_empty_irq_pending <= 1'b0;
      spdif_empty_irq_en <= 1'b0;
      spdif_dma_req_en <= 1'b0;
      spdif_empty_irq_pending <= 1'b0;
      hdmi_fifo_run <= 1'b0;
      spdif_fifo_run <= 1'b0;
    end else begin
      if (wr_dig_ctl) begin
        hdmi_mix_target_sel <= reg_wdata[`AFM_HDMI_MIX_SEL_HI:`AFM_HDMI_MIX_SEL_LO];
        hdmi_fifo_src_sel <= reg_wdata[`AFM_HDMI_SRC_BIT];
        spdif_fifo_src_sel <= reg_wdata[`AFM_SPDIF_SRC_BIT];
        hdmi_karaoke_mix_en <= reg_wdata[`AFM_HDMI_KARA_BIT];
        spdif_karaoke_mix_en <= reg_wdata[`AFM_SPDIF_KARA_BIT];
        spdif_tx_en <= reg_wdata[`AFM_SPDIF_EN_BIT];
        hdmi_empty_irq_en <= reg_wdata[`AFM_HDMI_IRQ_EN_BIT];
        hdmi_dma_req_en <= reg_wdata[`AFM_HDMI_DMA_EN_BIT];
        spdif_empty_irq_en <= reg_wdata[`AFM_SPDIF_IRQ_EN_BIT];
        spdif_dma_req_en <= reg_wdata[`AFM_SPDIF_DMA_EN_BIT];
        hdmi_fifo_run <= reg_wdata[`AFM_HDMI_RUN_BIT];
        spdif_fifo_run <= reg_wdata[`AFM_SPDIF_RUN_BIT];
      end
      // [R17] set on empty edge, set beats clear
      if (hdmi_empty && !hdmi_empty_d) begin
        hdmi_empty_irq_pending <= 1'b1;
      end else if (wr_dig_ctl && reg_wdata[`AFM_HDMI_IRQ_PEND_BIT]) begin
        hdmi_empty_irq_pending <= 1'b0;
      end
      // [R20] set on empty edge, set beats clear
      if (spdif_empty && !spdif_empty_d) begin
        spdif_empty_irq_pending <= 1'b1;
      end else if (wr_dig_ctl && reg_wdata[`AFM_SPDIF_IRQ_PEND_BIT]) begin
        spdif_empty_irq_pending <= 1'b0;
      end
    end
  end

  // Edge memories start at the reset-state flag levels to avoid a false edge
  always @(posedge mclk) begin
    if (rst) begin
      tx_empty_d <= 1'b1;
      rx_full_d <= 1'b0;
      hdmi_empty_d <= 1'b1;
      spdif_empty_d <= 1'b1;
    end else begin
      tx_empty_d <= tx_empty;
      rx_full_d <= rx_full;
      hdmi_empty_d <= hdmi_empty;
      spdif_empty_d <= spdif_empty;
    end
  end

  // Latest received voice sample, the mix source for every output path
  always @(posedge mclk) begin
    if (rst || !rx_fifo_run) begin
      voice <= 24'h00_0000;
    end else if (rx_push) begin
      voice <= rx_sample_in;
    end
  end

  // Transmit path: channel slot counter and mixed output sample
  always @(posedge mclk) begin
    if (rst || !tx_fifo_run) begin
      tx_chan <= 3'h0;
      tx_sample <= 24'h00_0000;
    end else if (tx_take) begin
      tx_chan <= next_chan(tx_chan_mode, tx_chan);
      // [R04] [R01] mix into selected slots
      if (tx_karaoke_mix_en && mix_hit(tx_mix_target_sel, tx_chan_mode, tx_chan, 1'b1)) begin
        tx_sample <= sat_add(tx_head, voice);
      end else begin
        tx_sample <= tx_head;
      end
    end
  end

  // HDMI path: same scheme; its front selection leaves the centre out
  always @(posedge mclk) begin
    if (rst || !hdmi_fifo_run) begin
      hdmi_chan <= 3'h0;
      hdmi_sample <= 24'h00_0000;
    end else if (hdmi_take) begin
      hdmi_chan <= next_chan(hdmi_chan_mode, hdmi_chan);
      // [R15] [R13] mix into selected slots
      if (hdmi_karaoke_mix_en &&
          mix_hit(hdmi_mix_target_sel, hdmi_chan_mode, hdmi_chan, 1'b0)) begin
        hdmi_sample <= sat_add(hdmi_head, voice);
      end else begin
        hdmi_sample <= hdmi_head;
      end
    end
  end

  // S/PDIF path is stereo only, so every slot is a mix target
  always @(posedge mclk) begin
    // [R16] disable returns path to reset
    if (rst || !spdif_fifo_run || !spdif_tx_en) begin
      spdif_chan <= 3'h0;
      spdif_sample <= 24'h00_0000;
    end else if (spdif_take) begin
      spdif_chan <= next_chan(`AFM_CHM_STEREO, spdif_chan);
      // [R15] S/PDIF mixing
      if (spdif_karaoke_mix_en) begin
        spdif_sample <= sat_add(spdif_head, voice);
      end else begin
        spdif_sample <= spdif_head;
      end
    end
  end

  // [R06] [R09] level DMA requests
  assign rx_dma_req = rx_full_dma_req_en && rx_full;
  assign tx_dma_req = tx_empty_dma_req_en && tx_empty;
  // [R18] [R21] drained to threshold
  assign hdmi_dma_req = hdmi_dma_req_en && (hdmi_level <= `AFM_DMA_LEVEL);
  assign spdif_dma_req = spdif_dma_req_en && (spdif_level <= `AFM_DMA_LEVEL);

  // [R25] pending meets enable
  assign irq = (rx_full_irq_pending && rx_full_irq_en) ||
    (tx_empty_irq_pending && tx_empty_irq_en) ||
    (hdmi_empty_irq_pending && hdmi_empty_irq_en) ||
    (spdif_empty_irq_pending && spdif_empty_irq_en);

  // [R03] [R07] read-only status in serial view
  assign ser_ctl_view = {11'h000, tx_mix_target_sel, tx_fifo_src_sel, rx_empty, 1'b0,
    tx_karaoke_mix_en, 2'h0, rx_full_irq_pending, rx_full_irq_en, rx_full_dma_req_en,
    rx_fifo_run, tx_full, 4'h0, tx_empty_irq_pending, tx_empty_irq_en,
    tx_empty_dma_req_en, tx_fifo_run};

  // [R19] full flags in digital view
  assign dig_ctl_view = {15'h0000, hdmi_mix_target_sel, hdmi_fifo_src_sel,
    spdif_fifo_src_sel, hdmi_karaoke_mix_en, spdif_karaoke_mix_en, spdif_tx_en,
    hdmi_empty_irq_en, hdmi_dma_req_en, hdmi_full, hdmi_empty_irq_pending,
    spdif_empty_irq_en, spdif_dma_req_en, spdif_full, spdif_empty_irq_pending,
    hdmi_fifo_run, spdif_fifo_run};

  // Registered read data; write-only and unmapped addresses read zero
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AFM_OFS_SER_CTL: reg_rdata <= ser_ctl_view;
        `AFM_OFS_DIG_CTL: reg_rdata <= dig_ctl_view;
        // [R12] oldest sample, low byte zero
        `AFM_OFS_RX_DATA: reg_rdata <= rx_empty ? 32'h0000_0000 : {rx_head, 8'h00};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // afm_mix_ctl

`default_nettype wire

// ---- bench/afm_mix_ctl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module afm_mix_ctl_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic tx_empty,
  input wire logic rx_full,
  input wire logic spdif_pop,
  input wire logic [23:0] spdif_sample,
  input wire logic spdif_empty,
  input wire logic spdif_tx_en_out,
  input wire logic hdmi_empty,
  input wire logic irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  logic [31:0] ser_q;
  logic [31:0] dig_q;
  // Shadow of control writes; enables are not visible at the ports
  always_ff @(posedge mclk) begin
    if (rst) begin
      ser_q <= 32'h0002_0000;
      dig_q <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (reg_addr == 8'h04) ser_q <= reg_wdata;
      if (reg_addr == 8'h10) dig_q <= reg_wdata;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (rst);
  sequence rx_read_s; reg_rd && reg_addr == 8'h0c; endsequence
  sequence tx_read_s; reg_rd && reg_addr == 8'h08; endsequence
  tx_dma_a: assert property (tx_dma_req == (ser_q[1] & tx_empty))
    else $error("tx dma request wrong");
  rx_dma_a: assert property (rx_dma_req == (ser_q[10] & rx_full))
    else $error("rx dma request wrong");
  tx_hold_a: assert property (!ser_q[0] |=> tx_empty)
    else $error("tx fifo not held");
  rx_hold_a: assert property (!ser_q[9] |=> !rx_full)
    else $error("rx fifo not held");
  hdmi_hold_a: assert property (!dig_q[1] |=> hdmi_empty)
    else $error("hdmi fifo not held");
  spdif_hold_a: assert property (!dig_q[0] |=> spdif_empty)
    else $error("spdif fifo not held");
  rx_low_a: assert property (rx_read_s |=> reg_rdata[7:0] == 8'h00)
    else $error("rx low byte not zero");
  tx_read_a: assert property (tx_read_s |=> reg_rdata == 32'h0000_0000)
    else $error("tx data readable");
  spdif_en_a: assert property (spdif_tx_en_out == dig_q[10])
    else $error("spdif enable mismatch");
  spdif_off_a: assert property (!spdif_tx_en_out && spdif_pop |=> spdif_sample == 24'h00_0000)
    else $error("spdif moved while off");
  irq_quiet_a: assert property (!(ser_q[11] | ser_q[2] | dig_q[9] | dig_q[5]) |-> !irq)
    else $error("irq without enable");
endmodule // afm_mix_ctl_props
bind afm_mix_ctl afm_mix_ctl_props i_props (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tx_empty(tx_empty), .rx_full(rx_full), .spdif_pop(spdif_pop), .spdif_sample(spdif_sample),
  .spdif_empty(spdif_empty), .spdif_tx_en_out(spdif_tx_en_out), .hdmi_empty(hdmi_empty),
  .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
`default_nettype wire

// ---- bench/afm_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module afm_link_model (
  input wire logic mclk,
  output logic rx_push,
  output logic [23:0] rx_sample_in,
  output logic tx_pop,
  output logic spdif_pop,
  output logic hdmi_pop
);
  initial begin
    {rx_push, tx_pop, spdif_pop, hdmi_pop} = 4'h0;
    rx_sample_in = 24'h00_0000;
  end
  // Receiver delivers one sample; line shows garbage once released
  task automatic push_rx(input logic [23:0] s);
    @(negedge mclk);
    rx_push = 1'b1;
    rx_sample_in = s;
    @(negedge mclk);
    rx_push = 1'b0;
    rx_sample_in = ~s;
  endtask
  // One take by a consumer (0 tx, 1 spdif, 2 hdmi), then an optional stall
  task automatic take(input int which, input int gap);
    @(negedge mclk);
    {hdmi_pop, spdif_pop, tx_pop} = 3'h1 << which;
    @(negedge mclk);
    {hdmi_pop, spdif_pop, tx_pop} = 3'h0;
    repeat (gap) @(negedge mclk);
  endtask
endmodule // afm_link_model
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin logic [31:0] g_, e_; g_ = (g); e_ = (e); checked++; \
  if (g_ !== e_) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g_, e_); end end
module tb;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic [1:0] tx_chan_mode = 0, hdmi_chan_mode = 0;
  logic [23:0] tx_sample, spdif_sample, hdmi_sample, rx_sample_in, v, q[$];
  logic tx_pop, spdif_pop, hdmi_pop, rx_push, tx_empty, rx_full, spdif_empty, hdmi_empty;
  logic spdif_tx_en_out, irq, tx_dma_req, rx_dma_req, spdif_dma_req, hdmi_dma_req;
  int error_cnt = 0, checked = 0;
  afm_mix_ctl i_afm_mix_ctl (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tx_pop(tx_pop),
    .tx_chan_mode(tx_chan_mode), .tx_sample(tx_sample), .tx_empty(tx_empty),
    .rx_push(rx_push), .rx_sample_in(rx_sample_in), .rx_full(rx_full),
    .spdif_pop(spdif_pop), .spdif_sample(spdif_sample), .spdif_empty(spdif_empty),
    .spdif_tx_en_out(spdif_tx_en_out), .hdmi_pop(hdmi_pop), .hdmi_chan_mode(hdmi_chan_mode),
    .hdmi_sample(hdmi_sample), .hdmi_empty(hdmi_empty), .irq(irq), .tx_dma_req(tx_dma_req),
    .rx_dma_req(rx_dma_req), .spdif_dma_req(spdif_dma_req), .hdmi_dma_req(hdmi_dma_req));
  afm_link_model i_afm_link_model (.mclk(mclk), .rx_push(rx_push),
    .rx_sample_in(rx_sample_in), .tx_pop(tx_pop), .spdif_pop(spdif_pop), .hdmi_pop(hdmi_pop));
  // 50 MHz clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Slot hit for a mix target select, slots FL FR SW C ...
  function automatic logic hit(input logic [1:0] sel, input int slot);
    return sel == 0 || (sel != 3 && slot < 2) || (sel[1] && slot == 3);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1;
    @(negedge mclk);
    reg_wr = 0;
  endtask
  // Read data lands one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge mclk);
    reg_rd = 0;
    r = reg_rdata;
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic close_out;
    $display("checked=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out;
  end
  initial begin
    void'($urandom(32'hfccf9839));
    repeat (10) @(posedge mclk);
    @(negedge mclk) rst = 0;
    rd(8'h04, d); `CHK(d, 32'h0002_0000)
    rd(8'h10, d); `CHK(d, 32'h0000_0000)
    done("reset");
    wr(8'h04, 32'h0000_0001);
    repeat (32) begin
      v = $urandom;
      q.push_back(v);
      wr(8'h08, {v, 8'ha5});
    end
    rd(8'h04, d); `CHK(d[8], 1'b1)
    rd(8'h08, d); `CHK(d, 32'h0000_0000)
    wr(8'h08, 32'hffff_ff00);
    for (int i = 0; i < 32; i++) begin
      i_afm_link_model.take(0, i % 3);
      `CHK(tx_sample, q.pop_front())
    end
    rd(8'h04, d); `CHK(d, 32'h0002_0009)
    wr(8'h04, 32'h0000_0007); `CHK({irq, tx_dma_req}, 2'h3)
    wr(8'h04, 32'h0000_000f); `CHK(irq, 1'b0)
    done("tx");
    wr(8'h04, 32'h0000_0e01);
    for (int i = 0; i < 17; i++) begin
      v = $urandom;
      if (i < 16) q.push_back(v);
      i_afm_link_model.push_rx(v);
    end
    `CHK({rx_full, irq, rx_dma_req}, 3'h7)
    for (int i = 0; i < 16; i++) begin
      rd(8'h0c, d); `CHK(d, {q.pop_front(), 8'h00})
    end
    rd(8'h0c, d); `CHK(d, 32'h0000_0000)
    rd(8'h04, d); `CHK(d, 32'h0002_1e01)
    wr(8'h04, 32'h0000_1201);
    done("rx");
    i_afm_link_model.push_rx(24'h00_0100);
    for (int k = 0; k < 4; k++) begin
      tx_chan_mode = 2'(1 + k % 2);
      wr(8'h04, {11'h0, 2'(k), 19'h0} | 32'h0000_8201);
      // Background channels written in stream order
      for (int i = 0; i < 6 + 2 * (k % 2); i++) wr(8'h08, {24'h00_1000 + 24'(i), 8'h00});
      for (int i = 0; i < 6 + 2 * (k % 2); i++) begin
        i_afm_link_model.take(0, 0);
        `CHK(tx_sample, 24'h00_1000 + 24'(i) + (hit(2'(k), i) ? 24'h00_0100 : 24'h0))
      end
    end
    tx_chan_mode = 2'h0;
    done("mix");
    wr(8'h10, 32'h0000_6733);
    wr(8'h04, 32'h0004_0001);
    wr(8'h08, 32'h0bad_0000);
    v = $urandom;
    wr(8'h30, {v, 8'h00});
    i_afm_link_model.take(0, 0); `CHK(tx_sample, v)
    i_afm_link_model.take(1, 0); `CHK(spdif_sample, v)
    i_afm_link_model.take(2, 0); `CHK(hdmi_sample, v)
    `CHK({irq, hdmi_dma_req, spdif_dma_req}, 3'h7)
    wr(8'h30, {v, 8'h00});
    wr(8'h10, 32'h0000_6003);
    i_afm_link_model.take(1, 0);
    `CHK({spdif_tx_en_out, spdif_sample, spdif_empty}, 26'h0)
    wr(8'h10, 32'h0000_0000);
    @(negedge mclk); `CHK({hdmi_empty, spdif_empty}, 2'h3)
    done("shared");
    close_out;
  end
endmodule // tb
`default_nettype wire
